// ===== core/ww_defines.vh
/*
 * ww_defines.vh - register offsets, field positions, reset values, key
 * words and cycle counts of the windowed watchdog.
 * assumes: included by the watchdog core and the testbench files; all counts are in pclk cycles.
 */
`ifndef WW_DEFINES_VH
`define WW_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define WW_CTRL_OFF    8'h00
`define WW_FLAG_OFF    8'h04
`define WW_TOVAL_OFF   8'h08
`define WW_WIN_OFF     8'h0C
`define WW_REFR_OFF    8'h10
`define WW_UNLK_OFF    8'h14
`define WW_TMR_OFF     8'h18

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define WW_B_ON        0
`define WW_B_CLKSEL    1
`define WW_B_IRQEN     2
`define WW_B_WINEN     3
`define WW_B_PERMIT    4
`define WW_B_HALTDBG   5
`define WW_B_STOPEN    6
`define WW_B_WAITEN    7

// ----------------------------------------------------------------------
// reset values and key words
// ----------------------------------------------------------------------
`define WW_CTRL_RST    8'hD3
`define WW_TOVAL_RST   32'h004C4B4C
`define WW_WIN_RST     32'h00000010
`define WW_UNLK_KEY1   16'hC520
`define WW_UNLK_KEY2   16'hD928
`define WW_REFR_KEY1   16'hA602
`define WW_REFR_KEY2   16'hB480

// ----------------------------------------------------------------------
// timing counts in bus clock cycles
// ----------------------------------------------------------------------
`define WW_WCT_CYC     9'd256
`define WW_GAP_CYC     5'd20
`define WW_IRQ_RST_CYC 9'd256

`endif

// ===== core/ww_watchdog.v
/*
 * ww_watchdog.v - windowed watchdog with unlock and refresh key sequences,
 * an APB register slave and interrupt-then-reset exception handling.
 * assumes: one bus clock pclk; the two timer clock sources arrive as pins
 * much slower than pclk and are sampled; debug/stop/wait are async pins.
 */
// Local design decisions: the address map and the APB slave port.
//
// Overview of operation
// RULE1: timer steps on low-power oscillator or external clock, chosen by control bit.
// RULE2: with update permit, key1 then key2 within 20 cycles unlocks configuration.
// RULE3: no configuration write is taken the cycle right after unlock.
// RULE4: a 256-cycle update window opens after unlock; configuration changes only inside.
// RULE5: each configuration register takes one write per unlock, then locks.
// RULE6: no configuration write during update window causes an exception.
// RULE7: unlock attempts inside the update window are ignored.
// RULE8: timer keeps old setup during update, restarts on new setup at close.
// RULE9: any non-key value written to the unlock register causes an exception.
// RULE10: unlock keys more than 20 cycles apart with permit set cause exception.
// RULE11: refresh during unlock sequence or update window is silently ignored.
// RULE12: first unlock key must arrive within 256 cycles after reset.
// RULE13: new setup applies at window close; stop, wait, debug, irq enables at once.
// RULE14: refresh key1 then key2 within 20 cycles restarts timer next cycle.
// RULE15: refresh keys too far apart or wrong refresh value cause exception.
// RULE16: unlock attempts between the two refresh keys are silently ignored.
// RULE17: windowed mode: refresh before window count causes exception.
// RULE18: disabled timer held at zero, no refresh; other exceptions still reset.
// RULE19: halt-in-debug pauses timer in debug; register access stays allowed.
// RULE20: in debug, windows and exceptions keep running on the bus clock.
// RULE21: debug entered in the reset window holds timer zero; exit restarts window.
// RULE22: with irq enabled, exception raises interrupt, then reset 256 cycles later.
// RULE23: pending interrupt flag clears when software writes one to it.
// RULE24: two time-outs without system reset drive reset out directly.
// RULE25: timer counts up and times out on reaching the time-out value.
//
`timescale 1ns/1ps
`default_nettype none
`include "ww_defines.vh"

module ww_watchdog #(
   parameter TMR_W = 32
) (
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // timer clock sources and mode pins (asynchronous)
   input  wire        low_power_osc,
   input  wire        ext_sys_clk,
   input  wire        debug_mode,
   input  wire        stop_mode,
   input  wire        wait_mode,
   // system outputs
   output reg         sys_reset_q,
   output reg         irq_pending_flag
);

   // ------------------------------------------------------------------
   // unlock sequencer states
   // ------------------------------------------------------------------
   localparam [3:0] S_LOCK = 4'h1;
   localparam [3:0] S_KEY1 = 4'h2;
   localparam [3:0] S_GAP  = 4'h4;
   localparam [3:0] S_UPD  = 4'h8;

   reg [3:0]       state_q;
   reg [4:0]       sync1_q;
   reg [4:0]       sync2_q;
   reg [1:0]       clk_old_q;
   reg [7:0]       ctrl_q;
   reg [31:0]      toval_q;
   reg [31:0]      win_q;
   reg             act_on_q;
   reg             act_clksel_q;
   reg             act_winen_q;
   reg [31:0]      act_toval_q;
   reg [31:0]      act_win_q;
   reg [2:0]       wdone_q;
   reg [8:0]       wct_q;
   reg [4:0]       gap_q;
   reg             ref1_q;
   reg             cfg_win_q;
   reg             dbg_hold_q;
   reg [TMR_W-1:0] tmr_q;
   reg             to_seen_q;
   reg             rst_pend_q;
   reg [8:0]       rst_cnt_q;

   // ------------------------------------------------------------------
   // two-flop synchronisers; bit 0 osc, 1 ext clk, 2 debug, 3 stop, 4 wait
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q   <= 5'h00;
         sync2_q   <= 5'h00;
         clk_old_q <= 2'h0;
      end else begin
         sync1_q   <= {wait_mode, stop_mode, debug_mode, ext_sys_clk, low_power_osc};
         sync2_q   <= sync1_q;
         clk_old_q <= sync2_q[1:0];
      end
   end

   wire dbg_s  = sync2_q[2];
   wire stop_s = sync2_q[3];
   wire wait_s = sync2_q[4];
   // rising edge of the selected source gives one timer step
   wire [1:0] clk_rise = sync2_q[1:0] & ~clk_old_q;
   wire tick = act_clksel_q ? clk_rise[0] : clk_rise[1]; // RULE1

   // ------------------------------------------------------------------
   // apb decode; writes take effect at the access edge
   // ------------------------------------------------------------------
   wire setup   = psel & ~penable;
   wire wr      = psel & penable & pready & pwrite;
   wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `WW_TMR_OFF);
   wire [15:0] wkey = pwdata[15:0];
   wire wr_ctrl  = wr && (paddr == `WW_CTRL_OFF);
   wire wr_flag  = wr && (paddr == `WW_FLAG_OFF);
   wire wr_toval = wr && (paddr == `WW_TOVAL_OFF);
   wire wr_win   = wr && (paddr == `WW_WIN_OFF);
   wire wr_refr  = wr && (paddr == `WW_REFR_OFF);
   wire wr_unlk  = wr && (paddr == `WW_UNLK_OFF);

   wire permit    = ctrl_q[`WW_B_PERMIT];
   wire upd_open  = (state_q == S_UPD); // RULE3
   wire gap_over  = (gap_q >= `WW_GAP_CYC);
   wire wct_last  = (wct_q == `WW_WCT_CYC - 9'd1);
   wire upd_close = upd_open && wct_last;

   // ------------------------------------------------------------------
   // unlock and refresh decode
   // ------------------------------------------------------------------
   reg exc_unlk;
   reg exc_refr;
   reg ref_ok;
   always @* begin
      exc_unlk = 1'b0;
      exc_refr = 1'b0;
      ref_ok   = 1'b0;
      // unlock register judged when idle with no refresh half done, and in S_KEY1 while key2 is awaited
      if (wr_unlk && (state_q == S_LOCK) && !ref1_q) begin // RULE7 RULE16
         if (wkey != `WW_UNLK_KEY1 && wkey != `WW_UNLK_KEY2)
            exc_unlk = 1'b1; // RULE9
      end
      if (state_q == S_KEY1) begin
         if (wr_unlk && wkey != `WW_UNLK_KEY1 && wkey != `WW_UNLK_KEY2)
            exc_unlk = 1'b1; // RULE9
         else if (!wr_unlk && gap_over && permit)
            exc_unlk = 1'b1; // RULE10
      end
      // refresh only counts while locked and enabled
      if (wr_refr && (state_q == S_LOCK) && act_on_q) begin // RULE11 RULE18
         if (!ref1_q) begin
            if (wkey != `WW_REFR_KEY1)
               exc_refr = 1'b1; // RULE15
         end else if (wkey == `WW_REFR_KEY2) begin
            if (act_winen_q && (tmr_q < act_win_q[TMR_W-1:0]))
               exc_refr = 1'b1; // RULE17
            else
               ref_ok = 1'b1; // RULE14
         end else if (wkey != `WW_REFR_KEY1) begin
            exc_refr = 1'b1; // RULE15
         end
      end else if (ref1_q && !wr_refr && gap_over) begin
         exc_refr = 1'b1; // RULE15
      end
   end

   wire exc_upd  = upd_close && (wdone_q == 3'h0); // RULE6
   wire exc_cwin = (state_q == S_LOCK) && cfg_win_q && !dbg_hold_q && wct_last; // RULE12

   // ------------------------------------------------------------------
   // unlock sequencer, gap and window counters
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= S_LOCK;
         wct_q      <= 9'h000;
         gap_q      <= 5'h00;
         ref1_q     <= 1'b0;
         cfg_win_q  <= 1'b1;
         dbg_hold_q <= 1'b0;
      end else begin
         // counters count by default; the gap counter saturates, the window counter wraps
         if (!gap_over)
            gap_q <= gap_q + 5'd1;
         wct_q <= wct_q + 9'd1;
         case (state_q)
            S_LOCK: begin
               if (wr_unlk && !ref1_q && permit && wkey == `WW_UNLK_KEY1) begin
                  state_q   <= S_KEY1; // RULE2
                  gap_q     <= 5'h00;
                  cfg_win_q <= 1'b0;
               end
               if (cfg_win_q && (dbg_s || dbg_hold_q))
                  wct_q <= 9'h000; // RULE21
               if (exc_cwin)
                  cfg_win_q <= 1'b0;
            end
            S_KEY1: begin
               if (wr_unlk && wkey == `WW_UNLK_KEY2 && !gap_over)
                  state_q <= S_GAP; // RULE2
               else if (wr_unlk && wkey == `WW_UNLK_KEY1)
                  gap_q <= 5'h00;
               else if (exc_unlk || (gap_over && !wr_unlk))
                  state_q <= S_LOCK;
            end
            S_GAP: begin
               state_q <= S_UPD; // RULE3
               wct_q   <= 9'h000;
            end
            S_UPD: begin
               if (wct_last)
                  state_q <= S_LOCK; // RULE4
            end
            default: state_q <= S_LOCK;
         endcase
         // refresh half-sequence tracking
         if (ref1_q && (ref_ok || exc_refr))
            ref1_q <= 1'b0;
         else if (wr_refr && state_q == S_LOCK && act_on_q && wkey == `WW_REFR_KEY1) begin
            ref1_q <= 1'b1;
            gap_q  <= 5'h00;
         end
         // debug inside the reset window parks the timer until debug ends
         if (cfg_win_q && dbg_s && state_q == S_LOCK)
            dbg_hold_q <= 1'b1; // RULE21
         else if (dbg_hold_q && !dbg_s) begin
            dbg_hold_q <= 1'b0;
            cfg_win_q  <= 1'b1; // RULE21
         end
      end
   end

   // ------------------------------------------------------------------
   // write-once configuration; on, clock select, window enable, time-out and window value staged until the window closes
   // ------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q       <= `WW_CTRL_RST;
         toval_q      <= `WW_TOVAL_RST;
         win_q        <= `WW_WIN_RST;
         wdone_q      <= 3'h0;
         act_on_q     <= 1'b1;
         act_clksel_q <= 1'b1;
         act_winen_q  <= 1'b0;
         act_toval_q  <= `WW_TOVAL_RST;
         act_win_q    <= `WW_WIN_RST;
      end else begin
         if (state_q == S_GAP)
            wdone_q <= 3'h0;
         // one accepted write per register per unlock
         if (upd_open && wr_ctrl && !wdone_q[0]) begin // RULE4 RULE5
            ctrl_q     <= pwdata[7:0];
            wdone_q[0] <= 1'b1;
         end
         if (upd_open && wr_toval && !wdone_q[1]) begin // RULE5
            toval_q    <= pwdata;
            wdone_q[1] <= 1'b1;
         end
         if (upd_open && wr_win && !wdone_q[2]) begin // RULE5
            win_q      <= pwdata;
            wdone_q[2] <= 1'b1;
         end
         // the remaining fields become live only at window close
         if (upd_close) begin // RULE13
            act_on_q     <= ctrl_q[`WW_B_ON];
            act_clksel_q <= ctrl_q[`WW_B_CLKSEL];
            act_winen_q  <= ctrl_q[`WW_B_WINEN];
            act_toval_q  <= toval_q;
            act_win_q    <= win_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // timer; stop, wait and debug enables act straight from ctrl_q
   // ------------------------------------------------------------------
   wire hold_zero = !act_on_q || dbg_hold_q; // RULE18 RULE21
   wire paused    = (dbg_s && ctrl_q[`WW_B_HALTDBG])
                  || (stop_s && !ctrl_q[`WW_B_STOPEN])
                  || (wait_s && !ctrl_q[`WW_B_WAITEN]); // RULE13 RULE19
   wire to_ev     = !hold_zero && (tmr_q >= act_toval_q[TMR_W-1:0]); // RULE25

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q     <= {TMR_W{1'b0}};
         to_seen_q <= 1'b0;
      end else begin
         // old setup keeps running through unlock; restart at close
         if (hold_zero || ref_ok || upd_close || to_ev)
            tmr_q <= {TMR_W{1'b0}}; // RULE8 RULE14
         else if (tick && !paused)
            tmr_q <= tmr_q + {{(TMR_W-1){1'b0}}, 1'b1}; // RULE25
         if (to_ev)
            to_seen_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // exceptions: reset now, or interrupt then reset after a delay
   // ------------------------------------------------------------------
   // debug masks none of these while pclk runs, except a reset-window debug hold masks exc_cwin and to_ev
   wire exc_any = exc_unlk || exc_refr || exc_upd || exc_cwin || to_ev; // RULE20
   wire irq_en  = ctrl_q[`WW_B_IRQEN];
   // a second time-out goes straight out, the irq grace is skipped
   wire backup  = to_ev && to_seen_q; // RULE24

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_pend_q       <= 1'b0;
         rst_cnt_q        <= 9'h000;
         sys_reset_q      <= 1'b0;
         irq_pending_flag <= 1'b0;
      end else begin
         if (exc_any && irq_en && !rst_pend_q) begin
            rst_pend_q <= 1'b1; // RULE22
            rst_cnt_q  <= 9'h000;
         end else if (rst_pend_q && rst_cnt_q != `WW_IRQ_RST_CYC - 9'd1) begin
            rst_cnt_q <= rst_cnt_q + 9'd1;
         end
         // held until the system reset comes back on presetn
         if (backup || (exc_any && !irq_en)
             || (rst_pend_q && rst_cnt_q == `WW_IRQ_RST_CYC - 9'd1))
            sys_reset_q <= 1'b1; // RULE22 RULE24
         // a new event beats a clear in the same cycle
         if (exc_any && irq_en)
            irq_pending_flag <= 1'b1; // RULE22
         else if (wr_flag && pwdata[0])
            irq_pending_flag <= 1'b0; // RULE23
      end
   end

   // ------------------------------------------------------------------
   // read mux and registered apb answer (one access cycle, no waits)
   // ------------------------------------------------------------------
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h00000000;
      case (paddr)
         `WW_CTRL_OFF:  rd_d = {24'h000000, ctrl_q};
         `WW_FLAG_OFF:  rd_d = {28'h0000000, dbg_hold_q, to_seen_q, upd_open, irq_pending_flag};
         `WW_TOVAL_OFF: rd_d = toval_q;
         `WW_WIN_OFF:   rd_d = win_q;
         `WW_TMR_OFF:   rd_d = tmr_q;
         default:       rd_d = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !addr_ok;
         prdata  <= (setup && !pwrite && addr_ok) ? rd_d : 32'h00000000;
      end
   end

endmodule // ww_watchdog

`default_nettype wire

// ===== testbench/ww_watchdog_properties.sv
/*
 * ww_watchdog_properties.sv - bus and exception properties of the watchdog.
 * assumes: bound to ww_watchdog; single pclk domain, presetn async low.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ww_defines.vh"

module ww_watchdog_chk (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // mode and system
   input wire logic        debug_mode,
   input wire logic        sys_reset_q,
   input wire logic        irq_pending_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // helper: cycles since reset and whether the reset window was served
   // ----------------------------------------------------------------
   wire logic  wr_acc = psel && penable && pready && pwrite;
   logic [8:0] cyc_q;
   logic       seen_q;
   // debug also excuses the window, so it counts as served
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_q  <= 9'h000;
         seen_q <= 1'b0;
      end else begin
         if (cyc_q != 9'h12D) cyc_q <= cyc_q + 9'h001;
         if ((wr_acc && paddr == `WW_UNLK_OFF) || debug_mode) seen_q <= 1'b1;
      end
   end

   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
      else $error("read data outside access");
   unmapped_err_a: assert property (psel && !penable && (paddr > 8'h18 || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access not refused");
   cfg_window_rst_a: assert property (cyc_q == 9'h12C && !seen_q |-> sys_reset_q)
      else $error("no reset after missed unlock window");
   reset_sticky_a: assert property (sys_reset_q |=> sys_reset_q)
      else $error("system reset dropped");
   irq_then_reset_a: assert property ($rose(irq_pending_flag) && !sys_reset_q |-> ##[255:257] sys_reset_q)
      else $error("reset not 256 cycles after interrupt");
   reset_not_early_a: assert property ($rose(irq_pending_flag) && !sys_reset_q |-> !sys_reset_q [*8])
      else $error("reset too soon after interrupt");
   irq_clear_a: assert property (wr_acc && paddr == `WW_FLAG_OFF && pwdata[0] && irq_pending_flag
                                 |=> !irq_pending_flag)
      else $error("interrupt flag not cleared");

   cover property ($rose(irq_pending_flag));
   cover property ($rose(sys_reset_q));
   cover property (pslverr);
endmodule // ww_watchdog_chk

bind ww_watchdog ww_watchdog_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .debug_mode(debug_mode), .sys_reset_q(sys_reset_q), .irq_pending_flag(irq_pending_flag));
`default_nettype wire

// ===== testbench/ww_cpu_model.sv
/*
 * ww_cpu_model.sv - software side of the watchdog: apb master with key tasks.
 * assumes: slave answers with pready; a hung slave is cut by the bench timer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ww_defines.vh"

module ww_cpu_model (
   // clock
   input  wire logic        pclk,
   // apb request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   // apb answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
   end

   // ----------------------------------------------------------------
   // one transfer: setup, access held until pready seen at an edge
   // ----------------------------------------------------------------
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
             output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no cycle count assumed: only the bench watchdog ends a wait for an answer
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, a, d, q, e);
   endtask

   // keys a few cycles apart, then the idle cycle before any update
   task unlock;
      wr(`WW_UNLK_OFF, {16'h0000, `WW_UNLK_KEY1});
      wr(`WW_UNLK_OFF, {16'h0000, `WW_UNLK_KEY2});
      @(posedge pclk);
   endtask

   task refresh;
      wr(`WW_REFR_OFF, {16'h0000, `WW_REFR_KEY1});
      wr(`WW_REFR_OFF, {16'h0000, `WW_REFR_KEY2});
   endtask
endmodule // ww_cpu_model
`default_nettype wire

// ===== testbench/tb_windowed_watchdog_unlock_refresh.sv
/*
 * tb_windowed_watchdog_unlock_refresh.sv - scenario bench of the watchdog.
 * assumes: ww_cpu_model drives apb; timer clock is the slow oscillator pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ww_defines.vh"

module tb_windowed_watchdog_unlock_refresh;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic [2:0]        osc_div = 3'h0;
   wire logic         psel, penable, pwrite, pready, pslverr, sys_reset_q, irq_pending_flag;
   wire logic [7:0]   paddr;
   wire logic [31:0]  pwdata, prdata;
   wire logic         low_power_osc;
   logic [31:0]       rd_q;
   logic              err_q;
   logic              dbg_pin = 1'b0;
   int                error_cnt = 0;
   int                samples_checked = 0;

   always #5 pclk = ~pclk;
   // oscillator at pclk/8, slow enough for the design's edge sampler
   always @(posedge pclk) osc_div <= osc_div + 3'h1;
   assign low_power_osc = osc_div[2];

   ww_watchdog DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_power_osc(low_power_osc), .ext_sys_clk(1'b0), .debug_mode(dbg_pin), .stop_mode(1'b0),
      .wait_mode(1'b0), .sys_reset_q(sys_reset_q), .irq_pending_flag(irq_pending_flag));
   ww_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int n); repeat (n) @(posedge pclk); endtask
   task chk_rst(input logic e); chk({31'h0, sys_reset_q}, {31'h0, e}); endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      u_cpu.xfer(1'b0, a, 32'h0, rd_q, err_q);
      chk(rd_q, exp);
   endtask
   // fresh reset for every scenario, since exceptions stick until presetn
   task boot(input logic unl);
      @(posedge pclk);
      presetn <= 1'b0;
      cyc(12);
      presetn <= 1'b1;
      if (unl) u_cpu.unlock();
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset_vals;
      boot(1'b0);
      rd_chk(`WW_CTRL_OFF, {24'h0, `WW_CTRL_RST});
      rd_chk(`WW_TOVAL_OFF, `WW_TOVAL_RST);
      rd_chk(`WW_WIN_OFF, `WW_WIN_RST);
      rd_chk(8'h1C, 32'h0);
      chk({31'h0, err_q}, 32'h1);
      cyc(300);
      chk_rst(1'b1);
   endtask
   task t_bad_unlock;
      boot(1'b0);
      u_cpu.wr(`WW_UNLK_OFF, 32'h00001234);
      cyc(2);
      chk_rst(1'b1);
   endtask
   task t_unlock_gap;
      boot(1'b0);
      u_cpu.wr(`WW_UNLK_OFF, {16'h0, `WW_UNLK_KEY1});
      cyc(25);
      chk_rst(1'b1);
   endtask
   task t_no_config;
      boot(1'b1);
      cyc(300);
      chk_rst(1'b1);
   endtask
   task t_window;
      int n;
      boot(1'b1);
      rd_chk(`WW_FLAG_OFF, 32'h2);
      u_cpu.wr(`WW_TOVAL_OFF, 32'h40);
      u_cpu.wr(`WW_TOVAL_OFF, 32'h80);
      u_cpu.wr(`WW_CTRL_OFF, 32'hD7);
      u_cpu.unlock();
      u_cpu.refresh();
      cyc(300);
      chk({30'h0, irq_pending_flag, sys_reset_q}, 32'h0);
      rd_chk(`WW_FLAG_OFF, 32'h0);
      rd_chk(`WW_TOVAL_OFF, 32'h40);
      cyc(300);
      chk({31'h0, irq_pending_flag}, 32'h0);
      n = 0;
      while (irq_pending_flag !== 1'b1 && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      chk({30'h0, irq_pending_flag, sys_reset_q}, 32'h2);
      u_cpu.wr(`WW_FLAG_OFF, 32'h1);
      cyc(1);
      chk({31'h0, irq_pending_flag}, 32'h0);
      cyc(300);
      chk_rst(1'b1);
   endtask
   task t_refresh;
      boot(1'b1);
      u_cpu.wr(`WW_TOVAL_OFF, 32'h400);
      cyc(400);
      u_cpu.xfer(1'b0, `WW_TMR_OFF, 32'h0, rd_q, err_q);
      chk({31'h0, rd_q > 32'h0}, 32'h1);
      u_cpu.wr(`WW_REFR_OFF, {16'h0, `WW_REFR_KEY1});
      u_cpu.wr(`WW_UNLK_OFF, 32'h0);
      u_cpu.wr(`WW_REFR_OFF, {16'h0, `WW_REFR_KEY2});
      u_cpu.xfer(1'b0, `WW_TMR_OFF, 32'h0, rd_q, err_q);
      chk({31'h0, rd_q < 32'h4}, 32'h1);
      chk_rst(1'b0);
      u_cpu.wr(`WW_REFR_OFF, 32'h5555);
      cyc(2);
      chk_rst(1'b1);
   endtask
   task t_win_mode;
      boot(1'b1);
      u_cpu.wr(`WW_CTRL_OFF, 32'hDB);
      cyc(300);
      u_cpu.refresh();
      cyc(2);
      chk_rst(1'b1);
   endtask
   task t_disabled;
      boot(1'b1);
      u_cpu.wr(`WW_CTRL_OFF, 32'hD2);
      cyc(400);
      rd_chk(`WW_TMR_OFF, 32'h0);
      u_cpu.wr(`WW_UNLK_OFF, 32'h0);
      cyc(2);
      chk_rst(1'b1);
   endtask

   // debug inside the reset window parks the timer; leaving it restarts the window
   task t_debug;
      boot(1'b0);
      dbg_pin <= 1'b1;
      cyc(300);
      chk_rst(1'b0);
      rd_chk(`WW_FLAG_OFF, 32'h8);
      dbg_pin <= 1'b0;
      cyc(300);
      chk_rst(1'b1);
   endtask

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // whole run is about 3600 cycles; the limit leaves ample margin
   initial begin
      #300000;
      error_cnt++;
      report_and_stop();
   end

   initial begin
      t_reset_vals();
      t_bad_unlock();
      t_unlock_gap();
      t_no_config();
      t_window();
      t_refresh();
      t_win_mode();
      t_disabled();
      t_debug();
      report_and_stop();
   end
endmodule // tb_windowed_watchdog_unlock_refresh
`default_nettype wire
